// file: pkg/arc_consts.svh
// Purpose: offsets, field positions, reset values of the config registers
// Assumes: APB byte address is four times the register index
// Notes: included by the register bank and its chop averager
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// register indices; byte address is index times four
`define ARC_IDX_RATE 6'h04
`define ARC_IDX_REFC 6'h05
`define ARC_IDX_MAG 6'h06
`define ARC_IDX_STAT 6'h0f

// reset values
`define ARC_RST_RATE 8'h14
`define ARC_RST_REFC 8'h10
`define ARC_RST_MAG 8'h00

// conversion rate control fields
`define ARC_B_CHOP 7
`define ARC_B_EXTCLK 6
`define ARC_B_SSHOT 5
`define ARC_B_LLFILT 4
`define ARC_RATE_HI 3
`define ARC_RATE_RSVD 4'hf

// reference control fields
`define ARC_MON_HI 7
`define ARC_MON_LO 6
`define ARC_B_PBYP 5
`define ARC_B_NBYP 4
`define ARC_SRC_HI 3
`define ARC_SRC_LO 2
`define ARC_PWR_HI 1

// excitation magnitude fields
`define ARC_B_RAIL 7
`define ARC_B_LSW 6
`define ARC_MAG_RO 8'h30
`define ARC_LVL_HI 3

// conversion result width
`define ARC_DW 24

`endif

// file: pkg/arc_pkg.sv
// Purpose: types shared by the config register bank
// Assumes: constants come from arc_consts.svh
// Notes: codes of the reference fields and the chop phase are enumerations here
package arc_pkg;
  `include "arc_consts.svh"

  typedef logic [7:0] arc_byte_t;                 // one register
  typedef logic signed [`ARC_DW-1:0] arc_data_t;  // one conversion result

  // phase of a global chop pair
  typedef enum logic {ARC_CHOP_FIRST, ARC_CHOP_SECOND} arc_chop_e;

  // reference monitor configuration codes
  typedef enum logic [1:0] {
    ARC_MON_OFF, ARC_MON_LOW, ARC_MON_LOW_MID, ARC_MON_LOW_PULL
  } arc_mon_e;

  // internal reference power codes
  typedef enum logic [1:0] {
    ARC_PWR_OFF, ARC_PWR_ON_PD_OFF, ARC_PWR_ALWAYS, ARC_PWR_RSVD
  } arc_pwr_e;

  // reference source codes
  typedef enum logic [1:0] {
    ARC_SRC_EXT_A, ARC_SRC_EXT_B, ARC_SRC_INTERNAL, ARC_SRC_RSVD
  } arc_src_e;
endpackage : arc_pkg

// file: rtl/arc_chop_avg.sv
// Purpose: global chop pairing and averaging of conversion results
// Assumes: results arrive as one-cycle strobes on pclk
// Notes: the second result of a pair is taken with inputs swapped
`timescale 1ns/1ps
`include "arc_consts.svh"
module arc_chop_avg
  import arc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chop_on,          // global chop enabled
  input wire logic in_valid,         // raw result strobe
  input wire arc_pkg::arc_data_t in_data,
  output logic swap,                 // input polarity swapped
  output logic out_valid,            // result strobe, one cycle
  output arc_pkg::arc_data_t out_data
);
  import arc_pkg::*;

  arc_chop_e phase, next_phase;      // which half of the pair
  arc_data_t first, next_first;      // held first result
  logic next_out_valid;
  arc_data_t next_out_data;
  logic signed [`ARC_DW:0] diff;     // one extra bit avoids overflow

  // swap follows phase: the second reading is the reversed one
  assign swap = chop_on && (phase == ARC_CHOP_SECOND);

  // next-state logic of the pair sequencer
  always_comb begin
    next_phase = phase;
    next_first = first;
    next_out_valid = 1'b0;
    next_out_data = out_data;
    diff = {first[`ARC_DW-1], first} - {in_data[`ARC_DW-1], in_data};
    if (!chop_on) begin
      // plain pass-through; pair restarts when chop is switched on
      next_phase = ARC_CHOP_FIRST;
      if (in_valid) begin
        next_out_valid = 1'b1;
        next_out_data = in_data;
      end
    end else if (in_valid) begin
      case (phase)
        ARC_CHOP_FIRST: begin
          next_first = in_data;
          next_phase = ARC_CHOP_SECOND;
        end
        ARC_CHOP_SECOND: begin
          // reversed reading is negated, so average is half the difference
          next_out_valid = 1'b1;
          next_out_data = diff[`ARC_DW:1];
          next_phase = ARC_CHOP_FIRST;
        end
        default: next_phase = ARC_CHOP_FIRST;
      endcase
    end
  end

  // registers of the pair sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= ARC_CHOP_FIRST;
      first <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      phase <= next_phase;
      first <= next_first;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end
endmodule : arc_chop_avg

// file: rtl/arc_regs.sv
// Purpose: rate, reference and excitation config registers over APB
// Assumes: power_down and conversion strobes come from pclk logic
// Notes: zero-wait slave; unmapped addresses answer with pslverr
//
// Operation
// - global chop swaps inputs, averages pairs
// - clock bit picks internal or external clock
// - mode bit picks continuous or single-shot
// - filter bit picks sinc3 or low-latency
// - four-bit rate code, 1111 reserved
// - reference monitor field sets monitors, pull-together
// - positive buffer enabled by default, bypass bit
// - negative buffer bypassed at reset
// - reference source field, 11 reserved
// - internal reference power field, power-down behaviour
// - reference control at 05h, reset 10h
// - excitation register at 06h, bits 5:4 zero
// - rate register at 04h, reset 14h
// - bit 7 enables output rail monitor
// - bit 6 closes switch, opens in power-down
// - magnitude field sets both sources, 0000 off
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "arc_consts.svh"
module arc_regs
  import arc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter side
  input wire logic power_down,
  input wire logic conv_valid,
  input wire arc_pkg::arc_data_t conv_data,
  output logic chop_swap,
  output logic result_valid,
  output arc_pkg::arc_data_t result_data,
  // conversion rate control
  output logic chop_enable,
  output logic ext_clock_select,
  output logic single_shot_mode,
  output logic low_latency_filter,
  output logic [3:0] rate_code,
  output logic rate_code_reserved,
  // reference control
  output logic reference_low_monitor,
  output logic reference_mid_monitor,
  output logic reference_pull_together,
  output logic positive_ref_buffer_bypass,
  output logic negative_ref_buffer_bypass,
  output logic [1:0] reference_source_select,
  output logic internal_reference_on,
  output logic reference_code_reserved,
  // excitation
  output logic output_rail_monitor_enable,
  output logic low_side_switch,
  output logic [3:0] excitation_current_level
);
  import arc_pkg::*;

  // ---------------- register storage ----------------
  arc_byte_t rate_ctl; // conversion_rate_control
  arc_byte_t next_rate_ctl;
  arc_byte_t ref_ctl; // reference_control
  arc_byte_t next_ref_ctl;
  arc_byte_t mag_ctl; // excitation_magnitude
  arc_byte_t next_mag_ctl;

  // ---------------- bus decode ----------------
  logic setup_ph;                        // first cycle of a transfer
  logic access_ph;                       // completing cycle
  logic wr_go;                           // write takes effect now
  logic lane0;                           // low byte lane enabled
  logic aligned;                         // word-aligned address
  logic hit_rate;
  logic hit_ref;
  logic hit_mag;
  logic hit_stat;
  logic mapped;                          // any register hit
  logic [31:0] next_prdata;
  logic next_pslverr;
  arc_byte_t status;                     // read-only live state

  // ---------------- decoded output stage ----------------
  logic next_chop_enable;
  logic next_ext_clock_select;
  logic next_single_shot_mode;
  logic next_low_latency_filter;
  logic [3:0] next_rate_code;
  logic next_rate_code_reserved;
  logic next_reference_low_monitor;
  logic next_reference_mid_monitor;
  logic next_reference_pull_together;
  logic next_positive_ref_buffer_bypass;
  logic next_negative_ref_buffer_bypass;
  logic [1:0] next_reference_source_select;
  logic next_internal_reference_on;
  logic next_reference_code_reserved;
  logic next_output_rail_monitor_enable;
  logic next_low_side_switch;
  logic [3:0] next_excitation_current_level;
  logic int_ref_live;                    // internal reference powered now
  // field views of the reference register
  arc_mon_e mon_code;
  arc_pwr_e pwr_code;
  arc_src_e src_code;

  // zero-wait slave: every access phase completes in its first cycle
  assign pready = 1'b1;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign lane0 = pstrb[0];
  assign aligned = (paddr[1:0] == 2'h0);

  // address decode; byte address is four times the register index
  assign hit_rate = aligned && (paddr[7:2] == `ARC_IDX_RATE);
  assign hit_ref = aligned && (paddr[7:2] == `ARC_IDX_REFC);
  assign hit_mag = aligned && (paddr[7:2] == `ARC_IDX_MAG);
  assign hit_stat = aligned && (paddr[7:2] == `ARC_IDX_STAT);
  assign mapped = hit_rate || hit_ref || hit_mag || hit_stat;

  // a write lands only at the completing edge of a mapped transfer
  assign wr_go = access_ph && pwrite && mapped && lane0;

  // field views as enumerations
  assign mon_code = arc_mon_e'(ref_ctl[`ARC_MON_HI:`ARC_MON_LO]);
  assign pwr_code = arc_pwr_e'(ref_ctl[`ARC_PWR_HI:0]);
  assign src_code = arc_src_e'(ref_ctl[`ARC_SRC_HI:`ARC_SRC_LO]);

  // internal reference: code 01 drops out in power-down, 10 stays on
  // power_down is same-clock logic, so it needs no synchroniser
  always_comb begin
    case (pwr_code)
      ARC_PWR_OFF: int_ref_live = 1'b0;
      ARC_PWR_ON_PD_OFF: int_ref_live = !power_down;
      ARC_PWR_ALWAYS: int_ref_live = 1'b1;
      // reserved code treated as off, the safe reading
      default: int_ref_live = 1'b0;
    endcase
  end

  // live status word, read at the status index
  always_comb begin
    // upper bits read as zero
    status = 8'h00;
    status[0] = internal_reference_on;
    status[1] = low_side_switch;
    status[2] = chop_swap;
    status[3] = rate_code_reserved;
    status[4] = reference_code_reserved;
    status[5] = power_down;
  end

  // next values of the three writable registers
  always_comb begin
    next_rate_ctl = rate_ctl;
    next_ref_ctl = ref_ctl;
    next_mag_ctl = mag_ctl;
    if (wr_go && hit_rate) begin
      next_rate_ctl = pwdata[7:0];
    end

    if (wr_go && hit_ref) begin
      next_ref_ctl = pwdata[7:0];
    end

    if (wr_go && hit_mag) begin
      // read-only bits stay zero whatever is written
      next_mag_ctl = pwdata[7:0] & ~`ARC_MAG_RO;
    end
  end

  // register storage; reset values fixed by the map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_ctl <= `ARC_RST_RATE;
      ref_ctl <= `ARC_RST_REFC;
      mag_ctl <= `ARC_RST_MAG;
    end else begin
      rate_ctl <= next_rate_ctl;
      ref_ctl <= next_ref_ctl;
      mag_ctl <= next_mag_ctl;
    end
  end

  // read data and error captured in setup, so they stand in access
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_ph) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = !mapped;
      if (!pwrite) begin
        if (hit_rate) begin
          next_prdata[7:0] = rate_ctl;
        end else if (hit_ref) begin
          next_prdata[7:0] = ref_ctl;
        end else if (hit_mag) begin
          next_prdata[7:0] = mag_ctl;
        end else if (hit_stat) begin
          next_prdata[7:0] = status;
        end
      end
    end else if (!psel) begin
      // idle bus: drop any error so it cannot leak into the next transfer
      next_pslverr = 1'b0;
    end
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // decode of register fields into control levels
  always_comb begin
    // conversion rate control
    next_chop_enable = rate_ctl[`ARC_B_CHOP];
    next_ext_clock_select = rate_ctl[`ARC_B_EXTCLK];
    next_single_shot_mode = rate_ctl[`ARC_B_SSHOT];
    next_low_latency_filter = rate_ctl[`ARC_B_LLFILT];
    next_rate_code = rate_ctl[`ARC_RATE_HI:0];
    next_rate_code_reserved =
      (rate_ctl[`ARC_RATE_HI:0] == `ARC_RATE_RSVD);

    // reference monitors
    next_reference_low_monitor = 1'b0;
    next_reference_mid_monitor = 1'b0;
    next_reference_pull_together = 1'b0;
    case (mon_code)
      ARC_MON_OFF: next_reference_low_monitor = 1'b0;
      ARC_MON_LOW: next_reference_low_monitor = 1'b1;
      ARC_MON_LOW_MID: begin
        next_reference_low_monitor = 1'b1;
        next_reference_mid_monitor = 1'b1;
      end
      ARC_MON_LOW_PULL: begin
        next_reference_low_monitor = 1'b1;
        next_reference_pull_together = 1'b1;
      end
      default: next_reference_low_monitor = 1'b0;
    endcase

    // buffers; a set bit bypasses, reset leaves only negative bypassed
    next_positive_ref_buffer_bypass = ref_ctl[`ARC_B_PBYP];
    next_negative_ref_buffer_bypass = ref_ctl[`ARC_B_NBYP];
    // source select passes the code; reserved code is flagged only
    next_reference_source_select = src_code;
    next_internal_reference_on = int_ref_live;
    next_reference_code_reserved =
      (src_code == ARC_SRC_RSVD) || (pwr_code == ARC_PWR_RSVD);

    // excitation
    next_output_rail_monitor_enable = mag_ctl[`ARC_B_RAIL];
    // switch is forced open whenever the device sits in power-down
    next_low_side_switch = mag_ctl[`ARC_B_LSW] && !power_down;
    // one code drives both sources; they stay off without the reference,
    // so a premature magnitude write does no harm
    next_excitation_current_level =
      int_ref_live ? mag_ctl[`ARC_LVL_HI:0] : 4'h0;
  end

  // decoded levels leave through flip-flops, glitch-free at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // rate
      chop_enable <= 1'b0;
      ext_clock_select <= 1'b0;
      single_shot_mode <= 1'b0;
      low_latency_filter <= 1'b1;
      rate_code <= 4'h4;
      rate_code_reserved <= 1'b0;

      // reference
      reference_low_monitor <= 1'b0;
      reference_mid_monitor <= 1'b0;
      reference_pull_together <= 1'b0;
      positive_ref_buffer_bypass <= 1'b0;
      negative_ref_buffer_bypass <= 1'b1;
      reference_source_select <= 2'h0;
      internal_reference_on <= 1'b0;
      reference_code_reserved <= 1'b0;

      // excitation
      output_rail_monitor_enable <= 1'b0;
      low_side_switch <= 1'b0;
      excitation_current_level <= 4'h0;
    end else begin
      // rate
      chop_enable <= next_chop_enable;
      ext_clock_select <= next_ext_clock_select;
      single_shot_mode <= next_single_shot_mode;
      low_latency_filter <= next_low_latency_filter;
      rate_code <= next_rate_code;
      rate_code_reserved <= next_rate_code_reserved;

      // reference
      reference_low_monitor <= next_reference_low_monitor;
      reference_mid_monitor <= next_reference_mid_monitor;
      reference_pull_together <= next_reference_pull_together;
      positive_ref_buffer_bypass <= next_positive_ref_buffer_bypass;
      negative_ref_buffer_bypass <= next_negative_ref_buffer_bypass;
      reference_source_select <= next_reference_source_select;
      internal_reference_on <= next_internal_reference_on;
      reference_code_reserved <= next_reference_code_reserved;

      // excitation
      output_rail_monitor_enable <= next_output_rail_monitor_enable;
      low_side_switch <= next_low_side_switch;
      excitation_current_level <= next_excitation_current_level;
    end
  end

  // global chop: the live register bit steers the pair sequencer
  // switching chop off drops a half-finished pair
  arc_chop_avg u_chop (
    .pclk(pclk),
    .presetn(presetn),
    .chop_on(rate_ctl[`ARC_B_CHOP]),
    .in_valid(conv_valid),
    .in_data(conv_data),
    .swap(chop_swap),
    .out_valid(result_valid),
    .out_data(result_data)
  );
endmodule : arc_regs

// file: tb/arc_regs_asserts.sv
// Purpose: concurrent checks on the config register bank ports
// Assumes: zero-wait apb slave, outputs follow a write two edges on
// Notes: bound to every arc_regs instance
`timescale 1ns/1ps
module arc_regs_asserts
  import arc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down,
  input wire logic conv_valid,
  input wire arc_pkg::arc_data_t conv_data,
  input wire logic result_valid,
  input wire arc_pkg::arc_data_t result_data,
  input wire logic chop_enable,
  input wire logic ext_clock_select,
  input wire logic single_shot_mode,
  input wire logic low_latency_filter,
  input wire logic [3:0] rate_code,
  input wire logic reference_low_monitor,
  input wire logic reference_mid_monitor,
  input wire logic reference_pull_together,
  input wire logic positive_ref_buffer_bypass,
  input wire logic negative_ref_buffer_bypass,
  input wire logic [1:0] reference_source_select,
  input wire logic internal_reference_on,
  input wire logic output_rail_monitor_enable,
  input wire logic low_side_switch,
  input wire logic [3:0] excitation_current_level
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completed write with the low byte lane enabled
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence

  // read access phase at one address
  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence

  AST_MODE_BITS: assert property (s_wr(8'h10) |-> ##2
    {chop_enable, ext_clock_select, single_shot_mode, low_latency_filter}
      == $past(pwdata[7:4], 2)) else $error("mode bits differ from write");
  AST_RATE_CODE: assert property (s_wr(8'h10) |-> ##2
    rate_code == $past(pwdata[3:0], 2)) else $error("rate code wrong");
  AST_MON_FIELD: assert property (s_wr(8'h14) |-> ##2
    reference_low_monitor == ($past(pwdata[7:6], 2) != 2'b00)
    && reference_mid_monitor == ($past(pwdata[7:6], 2) == 2'b10)
    && reference_pull_together == ($past(pwdata[7:6], 2) == 2'b11))
    else $error("monitor outputs wrong");
  AST_BUF_BYP: assert property (s_wr(8'h14) |-> ##2
    {positive_ref_buffer_bypass, negative_ref_buffer_bypass}
      == $past(pwdata[5:4], 2)) else $error("buffer bypass wrong");
  AST_REF_SRC: assert property (s_wr(8'h14) |-> ##2
    reference_source_select == $past(pwdata[3:2], 2))
    else $error("reference source wrong");
  AST_RAIL_EN: assert property (s_wr(8'h18) |-> ##2
    output_rail_monitor_enable == $past(pwdata[7], 2))
    else $error("rail monitor enable wrong");
  AST_SW_PD: assert property (power_down && $past(power_down)
    |-> !low_side_switch) else $error("switch closed in power-down");
  AST_LVL_OFF: assert property (!internal_reference_on ##1
    !internal_reference_on |-> excitation_current_level == 4'h0)
    else $error("current level with reference off");
  AST_RO_ZERO: assert property (s_rd(8'h18) |->
    prdata[5:4] == 2'b00) else $error("read-only bits not zero");
  AST_UNMAPPED: assert property (psel && penable
    && !(paddr inside {8'h10, 8'h14, 8'h18, 8'h3c})
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  AST_PASS: assert property (conv_valid && !chop_enable ##1
    !chop_enable |-> result_valid && result_data == $past(conv_data))
    else $error("result not passed through");
endmodule : arc_regs_asserts

bind arc_regs arc_regs_asserts arc_regs_asserts_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .power_down, .conv_valid, .conv_data,
  .result_valid, .result_data, .chop_enable, .ext_clock_select,
  .single_shot_mode, .low_latency_filter, .rate_code,
  .reference_low_monitor, .reference_mid_monitor,
  .reference_pull_together, .positive_ref_buffer_bypass,
  .negative_ref_buffer_bypass, .reference_source_select,
  .internal_reference_on, .output_rail_monitor_enable, .low_side_switch,
  .excitation_current_level
);

// file: tb/arc_regs_tb.sv
// Purpose: self-checking bench for the config register bank
// Assumes: zero-wait apb slave, byte addresses 10h, 14h, 18h
// Notes: software-side codes kept legal except in the reserved-code case
`timescale 1ns/1ps
module arc_regs_tb;
  import arc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic power_down = 1'b0;
  logic conv_valid = 1'b0;
  arc_data_t conv_data = '0;
  logic [31:0] prdata;
  logic pready, pslverr, chop_swap, result_valid;
  arc_data_t result_data;
  logic chop_enable, ext_clock_select, single_shot_mode, low_latency_filter;
  logic [3:0] rate_code, excitation_current_level;
  logic rate_code_reserved, reference_code_reserved, internal_reference_on;
  logic reference_low_monitor, reference_mid_monitor;
  logic reference_pull_together, positive_ref_buffer_bypass;
  logic negative_ref_buffer_bypass, output_rail_monitor_enable;
  logic low_side_switch;
  logic [1:0] reference_source_select;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 75;
  // outputs of each register gathered into one byte
  logic [7:0] obs_rate, obs_ref, obs_mag;
  assign obs_rate = {chop_enable, ext_clock_select, single_shot_mode,
                     low_latency_filter, rate_code};
  assign obs_ref = {reference_low_monitor, reference_mid_monitor,
                    reference_pull_together, positive_ref_buffer_bypass,
                    negative_ref_buffer_bypass, reference_source_select,
                    internal_reference_on};
  assign obs_mag = {output_rail_monitor_enable, low_side_switch, 2'b00,
                    excitation_current_level};

  arc_regs arc_regs_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .power_down, .conv_valid, .conv_data,
    .chop_swap, .result_valid, .result_data, .chop_enable,
    .ext_clock_select, .single_shot_mode, .low_latency_filter, .rate_code,
    .rate_code_reserved, .reference_low_monitor, .reference_mid_monitor,
    .reference_pull_together, .positive_ref_buffer_bypass,
    .negative_ref_buffer_bypass, .reference_source_select,
    .internal_reference_on, .reference_code_reserved,
    .output_rail_monitor_enable, .low_side_switch, .excitation_current_level
  );

  // 10 MHz clock
  always #50 pclk = ~pclk;

  // expected reference outputs; code 01 drops out in power-down
  function automatic logic [7:0] f_ref(input logic [7:0] r, input logic pd);
    logic on;
    on = (r[1:0] == 2'b10) || (r[1:0] == 2'b01 && !pd);
    return {r[7:6] != 2'b00, r[7:6] == 2'b10, r[7:6] == 2'b11, r[5:2], on};
  endfunction : f_ref

  // expected excitation outputs; no current without the reference
  function automatic logic [7:0] f_mag(input logic [7:0] m, input logic on,
                                       input logic pd);
    return {m[7], m[6] && !pd, 2'b00, on ? m[3:0] : 4'h0};
  endfunction : f_mag

  task automatic chk_byte(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_byte

  task automatic chk_data(input string nm, input arc_data_t exp,
                          input arc_data_t got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_data

  // one apb transfer; only the watchdog ends a wait on pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] st, output logic [7:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, a, d, 4'h1, r, e);
  endtask : wr

  // read back all three registers and compare their decoded outputs, reserved flags excepted
  task automatic audit(input logic [7:0] ra, input logic [7:0] rf,
                       input logic [7:0] mg);
    logic [7:0] r;
    logic e;
    logic [7:0] x;
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h10, 8'h00, 4'h0, r, e);
    chk_byte("rate reg", ra, r);
    apb(1'b0, 8'h14, 8'h00, 4'h0, r, e);
    chk_byte("ref reg", rf, r);
    apb(1'b0, 8'h18, 8'h00, 4'h0, r, e);
    chk_byte("mag reg", mg & 8'hcf, r);
    chk_byte("rate outs", ra, obs_rate);
    x = f_ref(rf, power_down);
    chk_byte("ref outs", x, obs_ref);
    chk_byte("mag outs", f_mag(mg, x[0], power_down), obs_mag);
  endtask : audit

  // one conversion strobe; returns just after the edge that takes it
  task automatic conv(input arc_data_t d);
    @(posedge pclk);
    conv_valid <= 1'b1;
    conv_data <= d;
    @(posedge pclk);
    conv_valid <= 1'b0;
    #1;
  endtask : conv

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // cuts a hang short; the run needs well under this
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("[FAIL] watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    logic [7:0] rate, refr, mag, r;
    logic e;
    arc_data_t a, b;
    logic signed [24:0] t;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    audit(8'h14, 8'h10, 8'h00);
    // first ten pass fixed rate and reference codes, then random
    for (int i = 0; i < 30; i++) begin
      rate = 8'($random(seed));
      refr = 8'($random(seed));
      mag = 8'($random(seed)) & 8'hcf;
      if (rate[3:0] > 4'h9) rate[3:0] = rate[3:0] - 4'h6;
      if (refr[3:2] == 2'b11) refr[3:2] = 2'b10;
      if (refr[1:0] == 2'b11) refr[1:0] = 2'b01;
      if (i < 10) begin
        rate[3:0] = 4'(i);
        refr = {2'(i), 2'b11, 2'(i % 3), 2'(i % 3)};
      end
      if (refr[3:2] == 2'b10) refr[5:4] = 2'b11;
      if (refr[1:0] == 2'b00) mag[3:0] = 4'h0;
      power_down <= 1'($random(seed));
      wr(8'h10, rate);
      wr(8'h14, refr);
      wr(8'h18, mag);
      audit(rate, refr, mag);
    end
    // read-only bits ignore ones, reference always on
    power_down <= 1'b1;
    wr(8'h14, 8'h32);
    wr(8'h18, 8'hff);
    audit(rate, 8'h32, 8'hff);
    // refused transfers leave registers untouched
    apb(1'b1, 8'h1c, 8'hff, 4'h1, r, e);
    chk_byte("unmapped err", 8'h01, {7'h0, e});
    apb(1'b0, 8'h11, 8'h00, 4'h0, r, e);
    chk_byte("unaligned err", 8'h01, {7'h0, e});
    chk_byte("unaligned data", 8'h00, r);
    audit(rate, 8'h32, 8'hff);
    // reserved codes flagged, reserved power reads as off
    wr(8'h10, 8'h1f);
    wr(8'h14, 8'h0f);
    apb(1'b0, 8'h3c, 8'h00, 4'h0, r, e);
    chk_byte("status", 8'h38, r);
    // chop off: results pass straight through
    wr(8'h10, 8'h14);
    a = arc_data_t'($random(seed) >>> 12);
    conv(a);
    chk_byte("pass valid", 8'h01, {7'h0, result_valid});
    chk_data("pass data", a, result_data);
    // chop on: pairs averaged, inputs swapped for the second
    wr(8'h10, 8'h94);
    repeat (2) @(posedge pclk);
    for (int j = 0; j < 4; j++) begin
      a = arc_data_t'($random(seed) >>> 12);
      b = arc_data_t'($random(seed) >>> 12);
      conv(a);
      chk_byte("first flags", 8'h01, {6'h0, result_valid, chop_swap});
      conv(b);
      t = a - b;
      chk_byte("second flags", 8'h02, {6'h0, result_valid, chop_swap});
      chk_data("chop avg", arc_data_t'(t >>> 1), result_data);
    end
    test_done();
  end
endmodule : arc_regs_tb
